// ==== hdl/ccl_pkg.sv ====
// Package: register map, field positions and reset values of the channel latches
package ccl_pkg;

  localparam int unsigned NUM_CH = 4;

  // Register byte offsets
  localparam logic [7:0] CFG_BASE    = 8'h00; // Channel n config at CFG_BASE + 4*n
  localparam logic [7:0] STATUS_OFS  = 8'h10;
  localparam logic [7:0] CH_STRIDE   = 8'h04;

  // Field positions in a channel config word
  localparam int unsigned F_ENC_BYP_N  = 0;
  localparam int unsigned F_TX_CKSEL   = 1;
  localparam int unsigned F_TX_RATE    = 2;
  localparam int unsigned F_REFRAME    = 3;
  localparam int unsigned F_RX_PWR_ON  = 4;
  localparam int unsigned F_RX_BIST_N  = 5;
  localparam int unsigned F_TX_BIST_N  = 6;
  localparam int unsigned CFG_W        = 7;

  // Reset value: encoder on, refclk input, full rate, framer on, rx off, bist off
  localparam logic [6:0] CFG_RESET = 7'h6B;

  // Status word: bit n = channel n has invalid rate/speed combination
  localparam int unsigned F_ST_BAD_RATE = 0;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One channel's latch set
  typedef struct packed {
    logic tx_selftest_off_n;
    logic rx_selftest_off_n;
    logic rx_channel_power_on;
    logic reframe_enable;
    logic tx_pll_rate_select;
    logic tx_input_clock_select;
    logic encoder_bypass_n;
  } ccl_cfg_s;

  // Per-channel decoded controls to the datapath
  typedef struct packed {
    logic       encode_on;
    logic       capture_on_refclk;
    logic       align_buffer_bypass;
    logic       capture_both_edges;
    logic [4:0] pll_multiplier;
    logic       txclk_out_double;
    logic       framer_hold;
    logic       rx_power_down;
    logic       rx_selftest_en;
    logic       tx_selftest_en;
  } ccl_ctl_s;

  localparam logic [4:0] PLL_MULT_FULL = 5'h0A; // x10
  localparam logic [4:0] PLL_MULT_HALF = 5'h14; // x20

endpackage : ccl_pkg

// ==== hdl/ccl_channel_config_latches.sv ====
// Per-channel configuration latches with an AXI4-Lite register slave
// Register map, byte offsets on a 32-bit bus
//   Offset 0x00 + 4*n: latch word of channel n, bits [6:0]
//   Offset 0x10: status word, read-only
//   Other offsets answer SLVERR and touch nothing
// Latch word bits
//   Bit 0 encoder on, bit 1 reference-clock capture
//   Bit 2 double rate, bit 3 reframe enable
//   Bit 4 receive power on, bit 5 receive self-test off
//   Bit 6 transmit self-test off, bits 31:7 read as zero
// Status word
//   Bit n high while channel n asks for double rate on a low strap
//   Other bits read as zero; writes are accepted and ignored
// Decoded controls, one set per channel
//   Encoder on, capture clock, phase-buffer bypass, both-edge capture
//   PLL multiplier, clock-output doubling, framer hold
//   Receive power-down, receive and transmit self-test enables
// Write timing
//   Address and data taken in either order, each on its own ready
//   Commit one edge after both halves are held, response raised there
//   No new halves taken while a response waits, so one write in flight
//   Decoded controls follow one edge after the latch word
// Read timing
//   Address taken while no read data waits
//   Data and response registered one edge later, held until taken
// Reset
//   Asynchronous, every latch at its initialization value
//   Decoded controls reset to the matching image, so no step on release
//   Strap synchroniser starts low; status bits settle a few edges later
// Strap inputs
//   Each strap passes three flops; a change counts once the last two agree
//   A one-edge glitch between stages two and three is ignored
// Limitations
//   Reserved rate and strap combination is flagged, never blocked
//   Software sees the flag and undoes the write itself
//   Only byte lane 0 carries latch bits; without it a write changes nothing
//   Unaligned offsets are refused rather than rounded down
// Trade-offs
//   Commit takes one extra edge so split halves pair without a bypass path
//   Controls are registered, costing one edge, to keep outputs glitch-free
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
module ccl_channel_config_latches #(
  parameter int unsigned NCH = ccl_pkg::NUM_CH
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Speed range straps, one per channel, asynchronous
  input  wire logic [NCH-1:0]      speed_range_select,
  // Decoded per-channel controls
  output ccl_pkg::ccl_ctl_s [NCH-1:0] chan_ctl
);

  typedef struct packed {
    // Latch image, one set per channel
    ccl_pkg::ccl_cfg_s [NCH-1:0] cfg;
    // Write halves waiting to pair
    logic                        aw_held;
    logic [7:0]                  aw_addr;
    logic                        w_held;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    // Write response
    logic                        bvalid;
    logic [1:0]                  bresp;
    // Read response
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
    // Strap synchroniser stages and settled value
    logic [NCH-1:0]              spd_s1;
    logic [NCH-1:0]              spd_s2;
    logic [NCH-1:0]              spd_s3;
    logic [NCH-1:0]              spd_q;
    // Status flags and decoded controls
    logic [NCH-1:0]              bad_rate;
    ccl_pkg::ccl_ctl_s [NCH-1:0] ctl;
  } ccl_state_s;

  ccl_state_s st_reg;
  ccl_state_s st_next;

  // Channel index width; a lone channel still needs one bit
  localparam int unsigned CH_IDX_W = (NCH > 1) ? $clog2(NCH) : 1;

  // Address decode helper: valid flag over the byte offset of a config word
  // Unaligned or out-of-range offsets come back invalid; all but the status offset answer SLVERR
  function automatic logic [8:0] ccl_decode(input logic [7:0] addr);
    logic [8:0] res;
    logic       aligned;
    logic       in_range;
    res      = 9'h000;
    aligned  = (addr[1:0] == 2'h0);
    in_range = (addr < ccl_pkg::CFG_BASE + 8'(NCH) * ccl_pkg::CH_STRIDE);
    if (aligned && in_range) begin
      res = {1'b1, addr - ccl_pkg::CFG_BASE};
    end
    return res;
  endfunction : ccl_decode

  logic                wr_go;
  logic                rd_go;
  logic [8:0]          wr_dec;
  logic [8:0]          rd_dec;
  logic [CH_IDX_W-1:0] wr_ch;
  logic [CH_IDX_W-1:0] rd_ch;

  // Each write half refused while it is held or a response is pending
  assign s_axi_awready = !st_reg.aw_held && !st_reg.bvalid;
  assign s_axi_wready  = !st_reg.w_held && !st_reg.bvalid;
  // Read address refused while read data waits
  assign s_axi_arready = !st_reg.rvalid;
  // Responses and controls straight from registers
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rresp   = st_reg.rresp;
  assign s_axi_rdata   = st_reg.rdata;
  assign chan_ctl      = st_reg.ctl;

  // Next-state logic: bus slave, latches, decode
  always_comb begin
    st_next = st_reg;
    wr_go   = 1'b0;
    rd_go   = 1'b0;
    wr_dec  = 9'h000;
    rd_dec  = 9'h000;
    wr_ch   = '0;
    rd_ch   = '0;

    // Capture address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end

    // Commit write once both halves are held
    // Held halves pair here, whichever edge each arrived on
    wr_go = st_reg.aw_held && st_reg.w_held;
    if (wr_go) begin
      wr_dec         = ccl_decode(st_reg.aw_addr);
      wr_ch          = CH_IDX_W'(wr_dec[7:2]);
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = ccl_pkg::RESP_OKAY;
      if (wr_dec[8]) begin
        // Only byte lane 0 holds latch bits; other lanes ignored
        if (st_reg.w_strb[0]) begin
          st_next.cfg[wr_ch] = st_reg.w_data[ccl_pkg::CFG_W-1:0];
        end
      end else if (st_reg.aw_addr == ccl_pkg::STATUS_OFS) begin
        // Status is read-only; the write is accepted and dropped
        st_next.bresp = ccl_pkg::RESP_OKAY;
      end else begin
        // Unmapped offset refused, nothing touched
        st_next.bresp = ccl_pkg::RESP_SLVERR;
      end
    end
    // Response dropped on the edge it is taken
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // Read path: one-cycle latency after address taken
    rd_go = s_axi_arvalid && s_axi_arready;
    if (rd_go) begin
      rd_dec         = ccl_decode(s_axi_araddr);
      rd_ch          = CH_IDX_W'(rd_dec[7:2]);
      st_next.rvalid = 1'b1;
      st_next.rresp  = ccl_pkg::RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      if (rd_dec[8]) begin
        // Latch word in the low bits, the rest zero
        st_next.rdata[ccl_pkg::CFG_W-1:0] = st_reg.cfg[rd_ch];
      end else if (s_axi_araddr == ccl_pkg::STATUS_OFS) begin
        // One flag bit per channel
        st_next.rdata[ccl_pkg::F_ST_BAD_RATE +: NCH] = st_reg.bad_rate;
      end else begin
        // Unmapped offset, data left zero
        st_next.rresp = ccl_pkg::RESP_SLVERR;
      end
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end

    // Strap synchroniser: change counts when stages two and three agree
    // Stage one feeds only stage two, so a metastable value stays contained
    st_next.spd_s1 = speed_range_select;
    st_next.spd_s2 = st_reg.spd_s1;
    st_next.spd_s3 = st_reg.spd_s2;
    for (int i = 0; i < NCH; i++) begin
      if (st_reg.spd_s2[i] == st_reg.spd_s3[i]) begin
        st_next.spd_q[i] = st_reg.spd_s3[i];
      end
    end

    // status flag: double rate while the strap reads low
    for (int i = 0; i < NCH; i++) begin
      st_next.bad_rate[i] = st_reg.cfg[i].tx_pll_rate_select && !st_reg.spd_q[i];
    end

    // Per-channel control decode, registered so outputs never glitch
    for (int i = 0; i < NCH; i++) begin
      st_next.ctl[i].encode_on           = st_reg.cfg[i].encoder_bypass_n;

      st_next.ctl[i].capture_on_refclk   = st_reg.cfg[i].tx_input_clock_select;
      st_next.ctl[i].align_buffer_bypass = st_reg.cfg[i].tx_input_clock_select;
      // input clock capture when select is 0 (capture_on_refclk low)

      st_next.ctl[i].capture_both_edges  = st_reg.cfg[i].tx_input_clock_select &&
                                           st_reg.cfg[i].tx_pll_rate_select;

      if (st_reg.cfg[i].tx_pll_rate_select) begin
        st_next.ctl[i].pll_multiplier    = ccl_pkg::PLL_MULT_HALF;
      end else begin
        st_next.ctl[i].pll_multiplier    = ccl_pkg::PLL_MULT_FULL;
      end
      st_next.ctl[i].txclk_out_double    = st_reg.cfg[i].tx_pll_rate_select;

      st_next.ctl[i].framer_hold         = !st_reg.cfg[i].reframe_enable;

      st_next.ctl[i].rx_power_down       = !st_reg.cfg[i].rx_channel_power_on;

      st_next.ctl[i].rx_selftest_en      = !st_reg.cfg[i].rx_selftest_off_n;
      st_next.ctl[i].tx_selftest_en      = !st_reg.cfg[i].tx_selftest_off_n;
    end
  end

  // Reset image of the decoded controls, matching latch reset values
  localparam ccl_pkg::ccl_ctl_s CTL_RESET = '{
    encode_on:           1'b1,
    capture_on_refclk:   1'b1,
    align_buffer_bypass: 1'b1,
    capture_both_edges:  1'b0,
    pll_multiplier:      ccl_pkg::PLL_MULT_FULL,
    txclk_out_double:    1'b0,
    framer_hold:         1'b0,
    rx_power_down:       1'b1,
    rx_selftest_en:      1'b0,
    tx_selftest_en:      1'b0
  };

  // State register; latches take their initialization values
  // Reset branch loads constants only, so release needs no settling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        st_reg.cfg[i] <= ccl_pkg::CFG_RESET;
        st_reg.ctl[i] <= CTL_RESET;
      end
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : ccl_channel_config_latches

// ==== tb/ccl_host_model.sv ====
// Host model: AXI4-Lite master that loads and reads the channel latches
module ccl_host_model (
  input  wire logic        clk,
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus; responses always accepted at once
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    s_axi_wstrb = 4'hF;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
  end
  // Both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask : wr
  // Read waits for the answer with no assumed latency
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    dat = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
endmodule : ccl_host_model

// ==== tb/ccl_assertions.sv ====
// Checker of latch decode and register handshake at the block ports
module ccl_checker #(
  parameter int unsigned NCH = 4
) (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire logic [7:0]                   s_axi_awaddr,
  input wire logic                         s_axi_awvalid,
  input wire logic                         s_axi_awready,
  input wire logic [31:0]                  s_axi_wdata,
  input wire logic [3:0]                   s_axi_wstrb,
  input wire logic                         s_axi_wvalid,
  input wire logic                         s_axi_wready,
  input wire logic                         s_axi_bvalid,
  input wire logic                         s_axi_arvalid,
  input wire logic                         s_axi_arready,
  input wire logic                         s_axi_rvalid,
  input wire ccl_pkg::ccl_ctl_s [NCH-1:0] chan_ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Both write halves taken in one cycle with byte lane 0 strobed
  logic wr_both;
  assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  property p_rst; $rose(rst_n) |-> chan_ctl == {NCH{14'h3944}}; endproperty
  a_rst: assert property (p_rst) else $error("controls not at reset values");
  property p_enc; wr_both && s_axi_awaddr == 8'h00 && !s_axi_wdata[0] |-> ##[1:4] !chan_ctl[0].encode_on; endproperty
  a_enc: assert property (p_enc) else $error("encoder still on");
  property p_rate; wr_both && s_axi_awaddr == 8'h08 && s_axi_wdata[2] |-> ##[1:4] chan_ctl[2].pll_multiplier == 5'h14 && chan_ctl[2].txclk_out_double; endproperty
  a_rate: assert property (p_rate) else $error("double rate not applied");
  property p_clk; chan_ctl[1].capture_on_refclk == chan_ctl[1].align_buffer_bypass; endproperty
  a_clk: assert property (p_clk) else $error("buffer bypass mismatch");
  property p_both; chan_ctl[2].capture_both_edges == (chan_ctl[2].capture_on_refclk && chan_ctl[2].txclk_out_double); endproperty
  a_both: assert property (p_both) else $error("both-edge capture mismatch");
  property p_wresp; wr_both |-> ##[1:2] s_axi_bvalid; endproperty
  a_wresp: assert property (p_wresp) else $error("write response late");
  property p_wrefuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wrefuse: assert property (p_wrefuse) else $error("write taken while response pending");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
endmodule : ccl_checker

bind ccl_channel_config_latches ccl_checker #(.NCH(NCH)) u_chk (
  .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .chan_ctl);

// ==== tb/test_channel_config_latches.sv ====
// Bench for the channel configuration latches
module test_channel_config_latches;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, speed_range_select;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  int          fails = 0;
  int          tests_run = 0;
  ccl_pkg::ccl_ctl_s [3:0] chan_ctl;
  ccl_channel_config_latches uut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .speed_range_select, .chan_ctl);
  ccl_host_model host (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  // Expected decoded controls from a config word
  function automatic ccl_pkg::ccl_ctl_s ctl_of(input logic [6:0] c);
    return {c[0], c[1], c[1], c[1] & c[2], c[2] ? 5'h14 : 5'h0A, c[2], !c[3], !c[4], !c[5], !c[6]};
  endfunction : ctl_of
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      host.rd(8'(4 * i), d, r);
      check(d, 32'h0000006B);
      check(chan_ctl[i], ctl_of(7'h6B));
    end
  endtask : t_reset
  // Upper bits must be dropped; neighbour channel left alone
  task automatic t_write();
    host.wr(8'h04, 32'hFFFFFF94, r);
    check(r, ccl_pkg::RESP_OKAY);
    host.rd(8'h04, d, r);
    check(d, 32'h00000014);
    check(chan_ctl[1], ctl_of(7'h14));
    check(chan_ctl[0], ctl_of(7'h6B));
    host.wr(8'h00, 32'h0000006A, r);
    host.rd(8'h00, d, r);
    check(chan_ctl[0], ctl_of(7'h6A));
  endtask : t_write
  // Double rate on a channel whose strap is low, on purpose
  task automatic t_rate();
    host.wr(8'h08, 32'h0000006F, r);
    host.rd(ccl_pkg::STATUS_OFS, d, r);
    check(d, 32'h00000004);
    check(chan_ctl[2], ctl_of(7'h6F));
  endtask : t_rate
  task automatic t_unmapped();
    host.wr(8'h20, 32'h0000007F, r);
    check(r, ccl_pkg::RESP_SLVERR);
    host.rd(8'h20, d, r);
    check(r, ccl_pkg::RESP_SLVERR);
  endtask : t_unmapped
  // Second reset mid-run restores the latch of channel 1, the only one read back
  task automatic t_rereset();
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    host.rd(8'h04, d, r);
    check(d, 32'h0000006B);
    check(chan_ctl[1], ctl_of(7'h6B));
  endtask : t_rereset
  task automatic end_of_test();
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // Watchdog at 10000 cycles, far beyond the few dozen cycles the tests need
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
  initial begin
    rst_n = 1'h0;
    speed_range_select = 4'h3;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_write();
    t_rate();
    t_unmapped();
    t_rereset();
    end_of_test();
  end
endmodule : test_channel_config_latches
